// *** hdl/mpi_mux4_gen.sv ***
// four-channel crank-synchronous multi-pulse command generator
//
// Decided for this implementation: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps

// Summary of operation
// - up to five gated pulses per channel cycle
// - outputs drive only when unlock token permits
// - one clock; all times counted in its ticks
// - master gate off blocks all five pulses
// - early and late pulses have own gates
// - second late pulse needs first late gate
// - primary starts at angle, lasts width ticks
// - first early pulse leads primary by ticks
// - second early pulse leads primary by ticks
// - first late pulse follows primary by gap
// - second late pulse follows first late pulse
// - timing parameters are 24-bit wrapping tick counts
// - end angle reached moves to next channel
// - one-cycle strobe at each end angle
// - angles and start and end comparisons in crank angle ticks
// - end angle stops channel pulses and rearms
module mpi_mux4_gen
  import mpi_pkg::*;
#(
  parameter int unsigned ANG_W = 16
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             clk_en,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  input  wire logic [ANG_W-1:0] crank_angle_tick,
  input  wire logic             unlock_token,
  output logic                  pulse_out_ch1,
  output logic                  pulse_out_ch2,
  output logic                  pulse_out_ch3,
  output logic                  pulse_out_ch4,
  output logic                  channel_switch_strobe,
  output logic      [1:0]       active_channel
);

  localparam int unsigned PRED_W = ANG_W + TICK_W;

  typedef struct packed {
    logic [NUM_CH-1:0][REGS_PER_CH-1:0][TICK_W-1:0] cfg;
    logic [1:0]                                      ch;
    mpi_state_e                                      st;
    logic [TICK_W-1:0]                               cnt;
    logic [1:0]                                      early_on;
    logic [1:0]                                      early_done;
    logic [1:0][TICK_W-1:0]                          early_cnt;
    logic [ANG_W-1:0]                                ang_prev;
    logic [TICK_W-1:0]                               per_cnt;
    logic [TICK_W-1:0]                               period;
    logic [NUM_CH-1:0]                               outs;
    logic                                            strobe;
    logic                                            wr_pend;
    logic [7:0]                                      wr_idx;
    logic [31:0]                                     rdata;
  } mpi_state_s;

  mpi_state_s                     r;
  mpi_state_s                     next_r;
  logic       [TICK_W-1:0]        ctrl;
  logic                           ang_step;
  logic                           start_hit;
  logic                           end_hit;
  logic       [ANG_W-1:0]         ang_left;
  logic       [PRED_W-1:0]        pred_ticks;
  logic                           pulse_on;
  logic                           addr_ok;
  logic       [7:0]               a_idx;
  logic       [TICK_W-1:0]        lead [2];
  logic       [TICK_W-1:0]        ewid [2];
  logic       [1:0]               egate;

  // current channel settings and crank events; start and end matched in angle ticks
  always_comb begin
    ctrl       = r.cfg[r.ch][REG_CTRL];
    ang_step   = crank_angle_tick != r.ang_prev;
    start_hit  = ang_step && (crank_angle_tick == r.cfg[r.ch][REG_START][ANG_W-1:0]);
    end_hit    = ang_step && (crank_angle_tick == r.cfg[r.ch][REG_END][ANG_W-1:0]);
    ang_left   = r.cfg[r.ch][REG_START][ANG_W-1:0] - crank_angle_tick;
    pred_ticks = PRED_W'(ang_left) * PRED_W'(r.period); // time left to primary start
    lead[0]    = r.cfg[r.ch][REG_E1_LEAD];
    lead[1]    = r.cfg[r.ch][REG_E2_LEAD];
    ewid[0]    = r.cfg[r.ch][REG_E1_W];
    ewid[1]    = r.cfg[r.ch][REG_E2_W];
    egate      = {ctrl[CTRL_E2], ctrl[CTRL_E1]};
  end

  // pulse level of the active channel from gates and sequence
  always_comb begin
    pulse_on = ctrl[CTRL_MASTER] && (
               (r.st == ST_PRI)
            || (r.early_on[0] && ctrl[CTRL_E1])
            || (r.early_on[1] && ctrl[CTRL_E2])
            || (r.st == ST_LATE1 && ctrl[CTRL_L1])
            || (r.st == ST_LATE2 && ctrl[CTRL_L1] && ctrl[CTRL_L2]));
  end

  // bus address phase decode
  always_comb begin
    a_idx   = haddr[9:2];
    addr_ok = (haddr[31:8] == 24'h00_0000) && (a_idx[3:0] < 4'(REGS_PER_CH));
  end

  // next value of the whole state
  always_comb begin
    next_r = r;
    // angle step period measurement for the time leads
    next_r.ang_prev = crank_angle_tick;
    if (ang_step) begin
      next_r.period  = r.per_cnt + 24'h00_0001;
      next_r.per_cnt = '0;
    end else if (r.per_cnt != '1) begin
      next_r.per_cnt = r.per_cnt + 24'h00_0001;
    end
    // early pulses: fire when predicted time to start falls to the lead
    for (int i = 0; i < 2; i++) begin
      if (r.early_on[i]) begin
        if (r.early_cnt[i] <= 24'h00_0001) begin
          next_r.early_on[i] = 1'b0;
        end
        next_r.early_cnt[i] = r.early_cnt[i] - 24'h00_0001;
      end else if (r.st == ST_WAIT && !r.early_done[i] && egate[i]
                   && pred_ticks <= PRED_W'(lead[i])) begin
        next_r.early_done[i] = 1'b1;
        next_r.early_on[i]   = ewid[i] != '0;
        next_r.early_cnt[i]  = ewid[i];
      end
    end
    // primary and late sequence
    unique case (r.st)
      ST_WAIT: begin
        if (start_hit) begin
          next_r.st  = ST_PRI;
          next_r.cnt = r.cfg[r.ch][REG_PRI_W];
        end
      end
      ST_PRI: begin
        if (r.cnt <= 24'h00_0001) begin
          next_r.st  = ctrl[CTRL_L1] ? ST_GAP1 : ST_DONE;
          next_r.cnt = r.cfg[r.ch][REG_L1_GAP];
        end else begin
          next_r.cnt = r.cnt - 24'h00_0001;
        end
      end
      ST_GAP1: begin
        if (r.cnt <= 24'h00_0001) begin
          next_r.st  = ST_LATE1;
          next_r.cnt = r.cfg[r.ch][REG_L1_W];
        end else begin
          next_r.cnt = r.cnt - 24'h00_0001;
        end
      end
      ST_LATE1: begin
        if (r.cnt <= 24'h00_0001) begin
          next_r.st  = ctrl[CTRL_L2] ? ST_GAP2 : ST_DONE;
          next_r.cnt = r.cfg[r.ch][REG_L2_GAP];
        end else begin
          next_r.cnt = r.cnt - 24'h00_0001;
        end
      end
      ST_GAP2: begin
        if (r.cnt <= 24'h00_0001) begin
          next_r.st  = ST_LATE2;
          next_r.cnt = r.cfg[r.ch][REG_L2_W];
        end else begin
          next_r.cnt = r.cnt - 24'h00_0001;
        end
      end
      ST_LATE2: begin
        if (r.cnt <= 24'h00_0001) begin
          next_r.st = ST_DONE;
        end else begin
          next_r.cnt = r.cnt - 24'h00_0001;
        end
      end
      ST_DONE: begin
        next_r.cnt = '0;
      end
      // unused code 7: fall back to waiting
      default: begin
        next_r.st = ST_WAIT;
      end
    endcase
    // end angle: stop everything, rearm, move to the next channel
    next_r.strobe = end_hit;
    if (end_hit) begin
      next_r.ch         = r.ch + 2'h1;
      next_r.st         = ST_WAIT;
      next_r.cnt        = '0;
      next_r.early_on   = '0;
      next_r.early_done = '0;
      next_r.early_cnt  = '0;
    end
    // only the active channel may pulse, and only while unlocked
    next_r.outs       = '0;
    next_r.outs[r.ch] = pulse_on && unlock_token && !end_hit;
    // bus write data phase: 24-bit wrap on time fields
    next_r.wr_pend = hsel && htrans[1] && hready && hwrite && addr_ok;
    next_r.wr_idx  = a_idx;
    if (r.wr_pend) begin
      next_r.cfg[r.wr_idx[5:4]][r.wr_idx[3:0]] = (r.wr_idx[3:0] == REG_CTRL)
          ? (hwdata[TICK_W-1:0] & CTRL_MASK) : hwdata[TICK_W-1:0];
    end
    // bus read data captured in the address phase
    if (hsel && htrans[1] && hready && !hwrite) begin
      next_r.rdata = '0;
      if (haddr == STATUS_ADDR) begin
        next_r.rdata[STAT_CH_LSB +: 2]  = r.ch;
        next_r.rdata[STAT_OUT_LSB +: 4] = r.outs;
        next_r.rdata[STAT_UNLOCK]       = unlock_token;
        next_r.rdata[STAT_ST_LSB +: 3]  = r.st;
      end else if (addr_ok) begin
        next_r.rdata[TICK_W-1:0] = r.cfg[a_idx[5:4]][a_idx[3:0]];
      end
    end
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge clk) begin
    if (srst) begin
      r <= '0;
      r.ch <= CH_RESET;
      r.st <= ST_WAIT;
    end else if (clk_en) begin
      r <= next_r;
    end
  end

  // outputs
  assign pulse_out_ch1         = r.outs[0];
  assign pulse_out_ch2         = r.outs[1];
  assign pulse_out_ch3         = r.outs[2];
  assign pulse_out_ch4         = r.outs[3];
  assign channel_switch_strobe = r.strobe;
  assign active_channel        = r.ch;
  assign hrdata                = r.rdata;
  assign hreadyout             = clk_en; // stall the bus while frozen
  assign hresp                 = 1'b0;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  property p_strobe_single;
    channel_switch_strobe && clk_en |=> !channel_switch_strobe;
  endproperty
  a_strobe_single: assert property (p_strobe_single)
    else $error("switch strobe longer than one cycle");

  property p_locked_quiet;
    clk_en && !unlock_token |=> r.outs == '0;
  endproperty
  a_locked_quiet: assert property (p_locked_quiet)
    else $error("output active without unlock token");

  property p_master_off;
    clk_en && !ctrl[CTRL_MASTER] |=> r.outs == '0;
  endproperty
  a_master_off: assert property (p_master_off)
    else $error("output active with master gate off");

  property p_channel_step;
    clk_en && end_hit |=> channel_switch_strobe && r.ch == $past(r.ch) + 2'h1;
  endproperty
  a_channel_step: assert property (p_channel_step)
    else $error("channel did not advance at end angle");

  property p_rearm;
    clk_en && end_hit |=> r.st == ST_WAIT && r.early_on == '0 && r.outs == '0;
  endproperty
  a_rearm: assert property (p_rearm)
    else $error("channel not rearmed at end angle");

  property p_primary_start;
    clk_en && r.st == ST_WAIT && start_hit && !end_hit
      |=> r.st == ST_PRI && r.cnt == $past(r.cfg[r.ch][REG_PRI_W]);
  endproperty
  a_primary_start: assert property (p_primary_start)
    else $error("primary pulse did not start at its angle");

  // with the first late gate off nothing drives outside early and primary
  property p_late2_needs_late1;
    clk_en && !ctrl[CTRL_L1] && r.early_on == '0 && r.st != ST_PRI
      |=> r.outs == '0;
  endproperty
  a_late2_needs_late1: assert property (p_late2_needs_late1)
    else $error("second late pulse without first late gate");

  property p_early_gate;
    clk_en && !r.early_on[0] ##1 r.early_on[0] |-> $past(ctrl[CTRL_E1]);
  endproperty
  a_early_gate: assert property (p_early_gate)
    else $error("first early pulse started while disabled");

  property p_write_wrap;
    clk_en && r.wr_pend && r.wr_idx[3:0] == REG_PRI_W
      |=> r.cfg[$past(r.wr_idx[5:4])][REG_PRI_W] == $past(hwdata[TICK_W-1:0]);
  endproperty
  a_write_wrap: assert property (p_write_wrap)
    else $error("width write not kept modulo 24 bits");

  // only the channel that was active may drive its output
  property p_active_only;
    clk_en |=> (r.outs & ~(NUM_CH'(1) << $past(r.ch))) == '0;
  endproperty
  a_active_only: assert property (p_active_only)
    else $error("output driven by an inactive channel");

  // strobe only follows an end angle
  property p_strobe_cause;
    clk_en && !end_hit |=> !channel_switch_strobe;
  endproperty
  a_strobe_cause: assert property (p_strobe_cause)
    else $error("switch strobe without end angle");

  // primary leaves its state when the width count runs out
  property p_primary_width;
    clk_en && r.st == ST_PRI && r.cnt <= 24'h00_0001 |=> r.st != ST_PRI;
  endproperty
  a_primary_width: assert property (p_primary_width)
    else $error("primary pulse outlasted its width");

  c_full_seq:    cover property (r.st == ST_LATE2 && pulse_on);
  c_early_both:  cover property (r.early_on == 2'b11);
  c_ch_wrap:     cover property (channel_switch_strobe && r.ch == 2'h0);
  c_locked_hold: cover property (pulse_on && !unlock_token);
  c_cut_primary: cover property (end_hit && r.st == ST_PRI);

endmodule

// *** hdl/mpi_pkg.sv ***
// package: constants, register map and states of the multi-pulse generator
package mpi_pkg;

  // time parameters are held as 24-bit tick counts
  localparam int unsigned TICK_W      = 24;
  localparam int unsigned NUM_CH      = 4;
  localparam int unsigned REGS_PER_CH = 12;

  // per-channel register block, word index inside the block
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_START     = 4'h1;
  localparam logic [3:0] REG_END       = 4'h2;
  localparam logic [3:0] REG_PRI_W     = 4'h3;
  localparam logic [3:0] REG_E1_LEAD   = 4'h4;
  localparam logic [3:0] REG_E1_W      = 4'h5;
  localparam logic [3:0] REG_E2_LEAD   = 4'h6;
  localparam logic [3:0] REG_E2_W      = 4'h7;
  localparam logic [3:0] REG_L1_GAP    = 4'h8;
  localparam logic [3:0] REG_L1_W      = 4'h9;
  localparam logic [3:0] REG_L2_GAP    = 4'hA;
  localparam logic [3:0] REG_L2_W      = 4'hB;

  // byte addresses: channel n block at n * CH_STRIDE, status word alone
  localparam logic [31:0] CH_STRIDE    = 32'h0000_0040;
  localparam logic [31:0] STATUS_ADDR  = 32'h0000_0100;

  // control word bit positions
  localparam int unsigned CTRL_MASTER  = 0;
  localparam int unsigned CTRL_E1      = 1;
  localparam int unsigned CTRL_E2      = 2;
  localparam int unsigned CTRL_L1      = 3;
  localparam int unsigned CTRL_L2      = 4;
  localparam logic [23:0] CTRL_MASK    = 24'h00_001F;

  // reset values: all gates off, all times zero
  localparam logic [23:0] CFG_RESET    = 24'h00_0000;
  localparam logic [1:0]  CH_RESET     = 2'h0;

  // status word fields
  localparam int unsigned STAT_CH_LSB  = 0;
  localparam int unsigned STAT_OUT_LSB = 4;
  localparam int unsigned STAT_UNLOCK  = 8;
  localparam int unsigned STAT_ST_LSB  = 12;

  // primary and late pulse sequence of the active channel
  typedef enum logic [2:0] {
    ST_WAIT,
    ST_PRI,
    ST_GAP1,
    ST_LATE1,
    ST_GAP2,
    ST_LATE2,
    ST_DONE
  } mpi_state_e;

endpackage

// *** tb/mpi_crank_model.sv ***
// partner model: crank position tracker and supervisor key stage
`timescale 1ns/1ps
module mpi_crank_model #(
  parameter int ANG_W   = 16,
  parameter int PERIOD  = 4,
  parameter int MAX_ANG = 200
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             run,
  input  wire logic             key_raw,
  output logic      [ANG_W-1:0] angle,
  output logic                  token
);
  int cnt;

  // angle steps one tick every PERIOD clocks, wraps at cycle end
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt   <= 0;
      angle <= '0;
    end else if (run) begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      if (cnt == PERIOD - 1) begin
        angle <= (angle == ANG_W'(MAX_ANG - 1)) ? '0 : angle + 1'b1;
      end
    end
  end

  // supervisor key passes exactly one register stage
  always_ff @(posedge clk) begin
    token <= key_raw;
  end
endmodule

// *** tb/mpi_mux4_gen_tb_top.sv ***
// testbench: bus access, crank cycles and pulse counts of the generator
`timescale 1ns/1ps
module mpi_mux4_gen_tb_top
  import mpi_pkg::*;
;
  logic        clk     = 1'b0;
  logic        srst    = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic        run     = 1'b0;
  logic        key_raw = 1'b1;
  logic        clk_en  = 1'b1;
  wire  logic [31:0] hrdata;
  wire  logic        hready;
  wire  logic [15:0] angle;
  wire  logic        token;
  wire  logic [3:0]  po;
  wire  logic        strobe;
  wire  logic        hresp;
  wire  logic [1:0]  achan;
  int          errors  = 0;
  int          n_tests = 0;
  int          hi[4];
  int          ed[4];
  int          fst[4];
  int          lst[4];

  always #10 clk = ~clk;

  mpi_mux4_gen #(.ANG_W(16)) dut (
    .clk(clk), .srst(srst), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
    .crank_angle_tick(angle), .unlock_token(token), .pulse_out_ch1(po[0]),
    .pulse_out_ch2(po[1]), .pulse_out_ch3(po[2]), .pulse_out_ch4(po[3]),
    .channel_switch_strobe(strobe), .active_channel(achan));

  mpi_crank_model #(.ANG_W(16)) crank (
    .clk(clk), .srst(srst), .run(run), .key_raw(key_raw), .angle(angle), .token(token));

  // verdict and end of run
  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for hready at a rising edge
  task wait_rdy;
    int n;
    n = 0;
    @(posedge clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        errors++;
        conclude();
      end
      @(posedge clk);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
  endtask

  task rd(input logic [31:0] a, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    wait_rdy();
    htrans <= 2'h0;
    wait_rdy();
    d = hrdata;
  endtask

  function automatic logic [31:0] ra(input int c, input logic [3:0] r);
    return CH_STRIDE * 32'(c) + 32'({r, 2'b00});
  endfunction

  // run one engine cycle and gather pulse statistics
  task run_cycle;
    int n;
    int se;
    int sh;
    logic ps;
    logic [3:0] pp;
    n = 0;
    se = 0;
    sh = 0;
    ps = 1'b0;
    pp = 4'h0;
    for (int i = 0; i < 4; i++) begin
      hi[i] = 0;
      ed[i] = 0;
      fst[i] = -1;
      lst[i] = -1;
    end
    run <= 1'b1;
    while (se < 4 || ps) begin
      @(posedge clk);
      n++;
      if (n > 3000) begin
        errors++;
        conclude();
      end
      for (int i = 0; i < 4; i++) begin
        if (po[i] === 1'b1) begin
          hi[i]++;
          ed[i] += int'(!pp[i]);
          fst[i] = (fst[i] < 0) ? n : fst[i];
          lst[i] = n;
        end
      end
      sh += int'(strobe === 1'b1);
      se += int'(strobe === 1'b1 && !ps);
      ps = (strobe === 1'b1);
      pp = po;
    end
    run <= 1'b0;
    check(32'(sh), 32'h4);
    check({30'h0, achan}, 32'h0);
  endtask

  task chk_out(input int c, input int h, input int e);
    check(32'(hi[c]), 32'(h));
    check(32'(ed[c]), 32'(e));
  endtask

  task t_regs;
    logic [31:0] d;
    rd(ra(0, REG_CTRL), d);
    check(d, {8'h00, CFG_RESET});
    rd(STATUS_ADDR, d);
    check(d, 32'h0000_0100);
    check({31'h0, hresp}, 32'h0);
    wr(ra(0, REG_CTRL), 32'hFFFF_FFFF);
    rd(ra(0, REG_CTRL), d);
    check(d, 32'h0000_001F);
    wr(ra(0, REG_PRI_W), 32'h0100_0002);
    rd(ra(0, REG_PRI_W), d);
    check(d, 32'h0000_0002);
    wr(32'h0000_0030, 32'hA5A5_A5A5);
    rd(32'h0000_0030, d);
    check(d, 32'h0000_0000);
    clk_en <= 1'b0;
    repeat (3) @(posedge clk);
    check({31'h0, hready}, 32'h0);
    clk_en <= 1'b1;
    rd(STATUS_ADDR, d);
    check(d, 32'h0000_0100);
    $display("test regs done");
  endtask

  // ends rise with channel and never wrap; 20 ticks after each start
  task t_four;
    for (int c = 0; c < 4; c++) begin
      wr(ra(c, REG_CTRL), 32'h1);
      wr(ra(c, REG_START), 32'(30 + 50 * c - 10 * (c / 3)));
      wr(ra(c, REG_END), 32'(50 + 50 * c - 10 * (c / 3)));
      wr(ra(c, REG_PRI_W), 32'(c + 1));
    end
    run_cycle();
    for (int c = 0; c < 4; c++) begin
      chk_out(c, c + 1, 1);
    end
    $display("test four done");
  endtask

  task t_late;
    for (int c = 1; c < 4; c++) begin
      wr(ra(c, REG_CTRL), 32'h0);
    end
    wr(ra(0, REG_CTRL), 32'h19);
    wr(ra(0, REG_PRI_W), 32'h0100_0003);
    wr(ra(0, REG_L1_GAP), 32'h2);
    wr(ra(0, REG_L1_W), 32'h4);
    wr(ra(0, REG_L2_GAP), 32'h3);
    wr(ra(0, REG_L2_W), 32'h5);
    run_cycle();
    chk_out(0, 12, 3);
    check(32'(lst[0] - fst[0] + 1), 32'd17);
    chk_out(1, 0, 0);
    wr(ra(0, REG_CTRL), 32'h11);
    run_cycle();
    chk_out(0, 3, 1);
    $display("test late done");
  endtask

  task t_five;
    wr(ra(0, REG_E1_LEAD), 32'd20);
    wr(ra(0, REG_E1_W), 32'h4);
    wr(ra(0, REG_E2_LEAD), 32'd60);
    wr(ra(0, REG_E2_W), 32'h3);
    wr(ra(0, REG_CTRL), 32'h1F);
    run_cycle();
    chk_out(0, 19, 5);
    wr(ra(0, REG_CTRL), 32'h1E);
    run_cycle();
    chk_out(0, 0, 0);
    wr(ra(0, REG_CTRL), 32'h1F);
    key_raw <= 1'b0;
    run_cycle();
    chk_out(0, 0, 0);
    key_raw <= 1'b1;
    $display("test five done");
  endtask

  // primary longer than its window is cut at the end angle
  task t_cut;
    wr(ra(0, REG_CTRL), 32'h1);
    wr(ra(0, REG_PRI_W), 32'd200);
    run_cycle();
    chk_out(0, 79, 1);
    check(32'(lst[0] - fst[0] + 1), 32'd79);
    $display("test cut done");
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_four();
    t_late();
    t_five();
    t_cut();
    conclude();
  end
endmodule
